/* irq_pm_pkg.sv */
// irq_pm_pkg: offsets, field positions, reset values and timing counts
// shared by the bridge interrupt, fault and power-management logic.
// assumes the host-port csr window decode happens upstream.
package irq_pm_pkg;

  // ----------------------------------------------------------------
  // host-port csr offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT_SET = 8'h00;
  localparam logic [7:0] OFS_EVENT_CLR = 8'h04;
  localparam logic [7:0] OFS_MASK_SET = 8'h08;
  localparam logic [7:0] OFS_MASK_CLR = 8'h0c;
  localparam logic [7:0] OFS_ERR_REPORT = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int BIT_GLOBAL_GATE = 31;
  localparam int BIT_PORT_FAULT = 30;
  localparam int BIT_PIN3_IRQ = 28;
  localparam int BIT_PIN2_IRQ = 27;
  localparam int BIT_READY_TO_DIS = 1;
  localparam int BIT_PM_REV_SEL = 4;
  localparam int BIT_WAKE_STATUS = 15;
  localparam int BIT_WAKE_ENABLE = 8;
  localparam int BIT_SYS_ERR_EN = 8;
  localparam int BIT_COLD_WAKE = 15;

  // writable bits of event and mask registers
  localparam logic [31:0] EVENT_WR_MASK = 32'h1800_000f;
  localparam logic [31:0] MASK_WR_MASK = 32'hd800_000f;
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [3:0] ERR_RESET = 4'h0;

  // ----------------------------------------------------------------
  // byte-enable patterns legal for a narrow dsp
  // ----------------------------------------------------------------
  localparam logic [3:0] BE_UPPER_OFF = 4'b1100;
  localparam logic [3:0] BE_LOWER_OFF = 4'b0011;
  localparam logic [3:0] BE_ALL_ON = 4'b0000;

  // ----------------------------------------------------------------
  // power-management capability fields
  // ----------------------------------------------------------------
  localparam logic [1:0] PWR_D0 = 2'b00;
  localparam logic [2:0] PM11_VERSION = 3'b010;
  localparam logic [2:0] AUX_CUR_COLD = 3'b001;
  localparam logic [2:0] AUX_CUR_NONE = 3'b000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int READY_TIMEOUT_CYC = 256;
  localparam int DISCARD_CYC_DEFAULT = 1024;
  localparam int TIMER_W = 16;

endpackage : irq_pm_pkg

/* port_fault_det.sv */
// port_fault_det: fault detection for one dsp host port.
// assumes select, ready and read-pending come from the same clock,
// ready already synchronised by the caller.
`timescale 1ns/100ps
module port_fault_det
  import irq_pm_pkg::*;
#(
  parameter int DISCARD_CYC = DISCARD_CYC_DEFAULT
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // port activity
  input wire logic port_select_n,
  input wire logic ready_n,
  input wire logic read_pending,
  input wire logic narrow_port,
  input wire logic be_valid,
  input wire logic [3:0] byte_en_n,
  // control
  input wire logic ready_timeout_disable,
  // result
  output logic fault_q
);

  logic [TIMER_W-1:0] ready_cnt_q;
  logic [TIMER_W-1:0] discard_cnt_q;
  logic ready_to;
  logic discard_to;
  logic be_bad;

  // ----------------------------------------------------------------
  // ready timeout
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst || port_select_n || !ready_n || ready_timeout_disable)
      ready_cnt_q <= '0;
    else if (ready_cnt_q != TIMER_W'(READY_TIMEOUT_CYC))
      ready_cnt_q <= ready_cnt_q + 1'b1;
  end

  assign ready_to = (ready_cnt_q == TIMER_W'(READY_TIMEOUT_CYC - 1)) && !port_select_n && ready_n
                    && !ready_timeout_disable;

  // ----------------------------------------------------------------
  // discard timer for pending reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst || !read_pending)
      discard_cnt_q <= '0;
    else if (discard_cnt_q != TIMER_W'(DISCARD_CYC))
      discard_cnt_q <= discard_cnt_q + 1'b1;
  end

  assign discard_to = read_pending && (discard_cnt_q == TIMER_W'(DISCARD_CYC - 1));

  assign be_bad = be_valid && narrow_port && (byte_en_n != BE_UPPER_OFF) && (byte_en_n != BE_LOWER_OFF)
                  && (byte_en_n != BE_ALL_ON);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fault_q <= 1'b0;
    else
      fault_q <= ready_to || discard_to || be_bad;
  end

  // a fault with no byte-enable or discard cause must come from a full wait
  ready_window_a: assert property (@(posedge clk_sys) disable iff (rst)
    fault_q && !$past(be_bad) && !$past(discard_to) |-> $past(ready_cnt_q) == TIMER_W'(READY_TIMEOUT_CYC - 1))
    else $error("early ready timeout");
  narrow_be_a: assert property (@(posedge clk_sys) disable iff (rst)
    be_bad |=> fault_q)
    else $error("bad byte enables not flagged");

endmodule : port_fault_det

/* irq_pm_ctrl.sv */
// irq_pm_ctrl: event and mask registers, host-port error report,
// inta and pme gating, fault-handling mode and pm capability fields.
// assumes csr accesses arrive as single-cycle strobes on clk_sys and
// gpio pins and dsp interrupt lines are asynchronous to it.
`timescale 1ns/100ps
module irq_pm_ctrl
  import irq_pm_pkg::*;
#(
  parameter int DISCARD_CYC = DISCARD_CYC_DEFAULT
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // csr access
  input wire logic csr_wr,
  input wire logic csr_rd,
  input wire logic [7:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata_q,
  // dsp host ports
  input wire logic [NUM_PORTS-1:0] dsp_host_irq_lines,
  input wire logic [NUM_PORTS-1:0] port_select_n,
  input wire logic [NUM_PORTS-1:0] narrow_dsp_ready_n,
  input wire logic [NUM_PORTS-1:0] wide_dsp_ready_n,
  input wire logic [NUM_PORTS-1:0] narrow_port,
  input wire logic [NUM_PORTS-1:0] read_pending,
  input wire logic [NUM_PORTS-1:0] be_valid,
  input wire logic [3:0] byte_en_n,
  // general-purpose pins
  input wire logic pin3_in,
  input wire logic pin2_in,
  input wire logic pin3_irq_select,
  input wire logic pin2_irq_select,
  input wire logic pin3_type_change,
  input wire logic pin2_type_change,
  // configuration bits
  input wire logic [7:0] diag_reg,
  input wire logic [7:0] misc_ctrl,
  input wire logic [15:0] pci_command,
  input wire logic [15:0] pm_csr,
  input wire logic [1:0] power_state,
  input wire logic cold_wake_support,
  input wire logic [15:9] pm_cap_hi,
  input wire logic pm_cap_bit5,
  input wire logic pm_cap_bit3,
  // error events
  input wire logic posted_write_err,
  input wire logic addr_parity_err,
  // outputs
  output logic inta_q,
  output logic pme_q,
  output logic target_abort_q,
  output logic zero_data_q,
  output logic serr_q,
  output logic [15:0] power_mgmt_capabilities_q
);

  logic [31:0] event_q;
  logic [31:0] event_d;
  logic [31:0] mask_q;
  logic [NUM_PORTS-1:0] per_port_fault_flags_q;
  logic [NUM_PORTS-1:0] port_fault;
  logic [NUM_PORTS-1:0] irq_s1_q, irq_s2_q;
  logic [2*NUM_PORTS-1:0] rdy_s1_q, rdy_s2_q;
  logic [NUM_PORTS-1:0] ready_n;
  logic [1:0] pin_s1_q, pin_s2_q, pin_prev_q;
  logic [1:0] pin_evt;
  logic host_port_fault;
  logic [31:0] pending;
  logic ready_timeout_disable;
  logic pm_rev_select;
  logic any_fault;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      rdy_s1_q <= '1;
      rdy_s2_q <= '1;
      pin_s1_q <= 2'b11;
      pin_s2_q <= 2'b11;
      pin_prev_q <= 2'b11;
    end
    else
    begin
      irq_s1_q <= dsp_host_irq_lines;
      irq_s2_q <= irq_s1_q;
      rdy_s1_q <= {narrow_dsp_ready_n, wide_dsp_ready_n};
      rdy_s2_q <= rdy_s1_q;
      pin_s1_q <= {pin3_in, pin2_in};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // low level or any change, chosen per pin
  assign pin_evt[1] = pin3_irq_select && (pin3_type_change ? (pin_s2_q[1] != pin_prev_q[1]) : !pin_s2_q[1]);
  assign pin_evt[0] = pin2_irq_select && (pin2_type_change ? (pin_s2_q[0] != pin_prev_q[0]) : !pin_s2_q[0]);

  assign ready_timeout_disable = diag_reg[BIT_READY_TO_DIS];
  assign pm_rev_select = misc_ctrl[BIT_PM_REV_SEL];
  // either ready pin answers; combined only after both are synchronised
  assign ready_n = rdy_s2_q[2*NUM_PORTS-1:NUM_PORTS] & rdy_s2_q[NUM_PORTS-1:0];

  // ----------------------------------------------------------------
  // per-port fault detectors
  // ----------------------------------------------------------------
  generate
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
      port_fault_det #(
        .DISCARD_CYC(DISCARD_CYC)
      ) u_det (
        .clk_sys(clk_sys),
        .rst(rst),
        .port_select_n(port_select_n[p]),
        .ready_n(ready_n[p]),
        .read_pending(read_pending[p]),
        .narrow_port(narrow_port[p]),
        .be_valid(be_valid[p]),
        .byte_en_n(byte_en_n),
        .ready_timeout_disable(ready_timeout_disable),
        .fault_q(port_fault[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // error report register: fault sets, write-one clears, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      per_port_fault_flags_q <= ERR_RESET;
    else if (csr_wr && hit(csr_addr, OFS_ERR_REPORT))
      per_port_fault_flags_q <= (per_port_fault_flags_q & ~csr_wdata[NUM_PORTS-1:0]) | port_fault;
    else
      per_port_fault_flags_q <= per_port_fault_flags_q | port_fault;
  end

  assign host_port_fault = |per_port_fault_flags_q;
  assign any_fault = |port_fault;

  // ----------------------------------------------------------------
  // event register; hardware sets win over software clears
  // ----------------------------------------------------------------
  always_comb
  begin
    event_d = event_q;
    if (csr_wr && hit(csr_addr, OFS_EVENT_SET))
      event_d = event_d | (csr_wdata & EVENT_WR_MASK);
    if (csr_wr && hit(csr_addr, OFS_EVENT_CLR))
      event_d = event_d & ~(csr_wdata & EVENT_WR_MASK);
    event_d[NUM_PORTS-1:0] = event_d[NUM_PORTS-1:0] | irq_s2_q;
    event_d[BIT_PIN3_IRQ] = event_d[BIT_PIN3_IRQ] | pin_evt[1];
    event_d[BIT_PIN2_IRQ] = event_d[BIT_PIN2_IRQ] | pin_evt[0];
    event_d = event_d & EVENT_WR_MASK;
    event_d[BIT_PORT_FAULT] = host_port_fault;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      event_q <= EVENT_RESET;
    else
      event_q <= event_d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mask_q <= MASK_RESET;
    else if (csr_wr && hit(csr_addr, OFS_MASK_SET))
      mask_q <= mask_q | (csr_wdata & MASK_WR_MASK);
    else if (csr_wr && hit(csr_addr, OFS_MASK_CLR))
      mask_q <= mask_q & ~(csr_wdata & MASK_WR_MASK);
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      csr_rdata_q <= '0;
    else if (csr_rd)
    begin
      if (hit(csr_addr, OFS_EVENT_SET))
        csr_rdata_q <= event_q;
      else if (hit(csr_addr, OFS_EVENT_CLR))
        csr_rdata_q <= event_q & mask_q;
      else if (hit(csr_addr, OFS_MASK_SET) || hit(csr_addr, OFS_MASK_CLR))
        csr_rdata_q <= mask_q;
      else if (hit(csr_addr, OFS_ERR_REPORT))
        csr_rdata_q <= {28'h0, per_port_fault_flags_q};
      else
        csr_rdata_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // inta and pme
  // ----------------------------------------------------------------
  // the fault bit is masked like any other, so bit 30 plus gate gives inta
  assign pending = event_q & mask_q & ~(32'h1 << BIT_GLOBAL_GATE);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      inta_q <= 1'b0;
    else
      inta_q <= mask_q[BIT_GLOBAL_GATE] && (|pending) && (power_state == PWR_D0);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pme_q <= 1'b0;
    else
      pme_q <= (|pending) && pm_csr[BIT_WAKE_STATUS] && pm_csr[BIT_WAKE_ENABLE];
  end

  // ----------------------------------------------------------------
  // fault-handling mode: abort or zero data, serr
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      target_abort_q <= 1'b0;
      zero_data_q <= 1'b0;
    end
    else
    begin
      target_abort_q <= any_fault && !mask_q[BIT_PORT_FAULT];
      zero_data_q <= any_fault && mask_q[BIT_PORT_FAULT];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      serr_q <= 1'b0;
    else
      serr_q <= pci_command[BIT_SYS_ERR_EN] && (addr_parity_err
                || (posted_write_err && !mask_q[BIT_PORT_FAULT]));
  end

  // ----------------------------------------------------------------
  // power-management capabilities read-only view
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      power_mgmt_capabilities_q <= '0;
    else if (pm_rev_select)
      power_mgmt_capabilities_q <= {pm_cap_hi,
                                    (cold_wake_support ? AUX_CUR_COLD : AUX_CUR_NONE),
                                    pm_cap_bit5, 1'b0, pm_cap_bit3, PM11_VERSION};
    else
      power_mgmt_capabilities_q <= {pm_cap_hi, 3'b000, pm_cap_bit5, 1'b1, pm_cap_bit3, 3'b001};
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  fault_or_a: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 event_q[BIT_PORT_FAULT] == $past(host_port_fault))
    else $error("fault bit not or of report");
  dsp_event_a: assert property (@(posedge clk_sys) disable iff (rst)
    irq_s2_q[0] |=> event_q[0])
    else $error("dsp event lost");
  inta_d0_a: assert property (@(posedge clk_sys) disable iff (rst)
    (power_state != PWR_D0) |=> !inta_q)
    else $error("inta outside d0");
  inta_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    inta_q |-> $past(mask_q[BIT_GLOBAL_GATE]) && $past(|pending))
    else $error("inta without cause");
  clr_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    csr_rd && hit(csr_addr, OFS_EVENT_CLR) |=> csr_rdata_q == $past(event_q & mask_q))
    else $error("clear read wrong");
  abort_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    mask_q[BIT_PORT_FAULT] |=> !target_abort_q)
    else $error("abort in zero-data mode");
  fault_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    any_fault |=> zero_data_q == $past(mask_q[BIT_PORT_FAULT]) && target_abort_q != zero_data_q)
    else $error("fault mode response wrong");
  serr_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    addr_parity_err && pci_command[BIT_SYS_ERR_EN] |=> serr_q)
    else $error("parity serr missing");
  pme_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    pme_q |-> $past(pm_csr[BIT_WAKE_ENABLE]) && $past(pm_csr[BIT_WAKE_STATUS]))
    else $error("pme without wake bits");
  err_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    port_fault[0] |=> per_port_fault_flags_q[0] ##1 event_q[BIT_PORT_FAULT])
    else $error("port fault not recorded");
  cap_rev_a: assert property (@(posedge clk_sys) disable iff (rst)
    pm_rev_select |=> power_mgmt_capabilities_q[2:0] == PM11_VERSION && !power_mgmt_capabilities_q[4])
    else $error("pm 1.1 layout wrong");

endmodule : irq_pm_ctrl

/* dsp_port_model.sv */
// dsp_port_model: behavioural dsp host-port side of the bridge.
// assumes it shares clk_sys with the bridge fault logic.
`timescale 1ns/100ps
module dsp_port_model
  import irq_pm_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // bridge side
  input wire logic [NUM_PORTS-1:0] port_select_n,
  input wire logic [NUM_PORTS-1:0] narrow_port,
  // test control
  input wire logic [NUM_PORTS-1:0] stall,
  // dsp ready lines
  output logic [NUM_PORTS-1:0] narrow_dsp_ready_n,
  output logic [NUM_PORTS-1:0] wide_dsp_ready_n
);
  logic [NUM_PORTS-1:0] sel_d1_q;
  logic [NUM_PORTS-1:0] sel_d2_q;
  // ------------------------------------------------------------
  // ready answer
  // ------------------------------------------------------------
  // ready two clocks after select; a stalled dsp never answers, like one
  // that lost power. unselected ports idle at the pulled-up level.
  always_ff @(posedge clk_sys)
  begin
    sel_d1_q <= ~port_select_n;
    sel_d2_q <= sel_d1_q & ~port_select_n;
  end
  assign narrow_dsp_ready_n = ~(sel_d2_q & ~stall & narrow_port & ~port_select_n);
  assign wide_dsp_ready_n = ~(sel_d2_q & ~stall & ~narrow_port & ~port_select_n);
endmodule : dsp_port_model

/* irq_pm_ctrl_tb.sv */
// irq_pm_ctrl_tb: self-checking bench for the interrupt, fault and pm logic.
// assumes the hand-over timing: registered outputs, read data one cycle late.
`timescale 1ns/100ps
module irq_pm_ctrl_tb;
  import irq_pm_pkg::*;
  localparam int DISC = 8;
  logic clk_sys = 1'b0, rst = 1'b1, csr_wr = 1'b0, csr_rd = 1'b0, rd_d = 1'b0;
  logic [7:0] csr_addr = 8'h00, diag_reg = 8'h00, misc_ctrl = 8'h00;
  logic [31:0] csr_wdata = 32'h0, csr_rdata_q, r, e;
  logic [3:0] dsp_host_irq_lines = 4'h0, port_select_n = 4'hf, narrow_port = 4'h0, stall = 4'h0;
  logic [3:0] read_pending = 4'h0, be_valid = 4'h0, byte_en_n = 4'h0, nrdy_n, wrdy_n;
  logic pin3_in = 1'b1, pin2_in = 1'b1, pin3_sel = 1'b0, pin2_sel = 1'b0, cold_wake_support = 1'b0;
  logic p3_chg = 1'b0, p2_chg = 1'b1;
  logic [15:0] pci_command = 16'h0100, pm_csr = 16'h0000, power_mgmt_capabilities_q;
  logic [1:0] power_state = PWR_D0;
  logic [15:9] pm_cap_hi = 7'h00;
  logic pm_cap_bit5 = 1'b0, pm_cap_bit3 = 1'b0, pw_err = 1'b0, ap_err = 1'b0;
  logic inta_q, pme_q, target_abort_q, zero_data_q, serr_q;
  logic [31:0] exp_q[$];
  logic [3:0] be_tab[4] = '{BE_UPPER_OFF, BE_LOWER_OFF, BE_ALL_ON, 4'b0101};
  int n_errors = 0, num_checks = 0, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  dsp_port_model u_far (.clk_sys(clk_sys), .port_select_n(port_select_n), .narrow_port(narrow_port),
    .stall(stall), .narrow_dsp_ready_n(nrdy_n), .wide_dsp_ready_n(wrdy_n));

  irq_pm_ctrl #(.DISCARD_CYC(DISC)) u_dut (.clk_sys(clk_sys), .rst(rst), .csr_wr(csr_wr), .csr_rd(csr_rd),
    .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rdata_q(csr_rdata_q),
    .dsp_host_irq_lines(dsp_host_irq_lines), .port_select_n(port_select_n), .narrow_dsp_ready_n(nrdy_n),
    .wide_dsp_ready_n(wrdy_n), .narrow_port(narrow_port), .read_pending(read_pending), .be_valid(be_valid),
    .byte_en_n(byte_en_n), .pin3_in(pin3_in), .pin2_in(pin2_in), .pin3_irq_select(pin3_sel),
    .pin2_irq_select(pin2_sel), .pin3_type_change(p3_chg), .pin2_type_change(p2_chg), .diag_reg(diag_reg),
    .misc_ctrl(misc_ctrl), .pci_command(pci_command), .pm_csr(pm_csr), .power_state(power_state),
    .cold_wake_support(cold_wake_support), .pm_cap_hi(pm_cap_hi), .pm_cap_bit5(pm_cap_bit5),
    .pm_cap_bit3(pm_cap_bit3), .posted_write_err(pw_err), .addr_parity_err(ap_err), .inta_q(inta_q),
    .pme_q(pme_q), .target_abort_q(target_abort_q), .zero_data_q(zero_data_q), .serr_q(serr_q),
    .power_mgmt_capabilities_q(power_mgmt_capabilities_q));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] seen);
    num_checks++;
    if (seen !== ex)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    csr_wr = 1'b1;
    csr_addr = a;
    csr_wdata = d;
    @(negedge clk_sys);
    csr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    @(negedge clk_sys);
    csr_rd = 1'b1;
    csr_addr = a;
    exp_q.push_back(ex);
    @(negedge clk_sys);
    csr_rd = 1'b0;
  endtask : rd

  // serr after a one-cycle error pulse; sel 1 = posted write, 0 = parity
  task automatic serr_pulse(input logic sel, input logic ex);
    @(negedge clk_sys);
    pw_err = sel;
    ap_err = ~sel;
    @(negedge clk_sys);
    pw_err = 1'b0;
    ap_err = 1'b0;
    chk("serr", {31'h0, ex}, {31'h0, serr_q});
    cyc(2);
  endtask : serr_pulse

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // result watcher and hang guard
  // ------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    rd_d <= csr_rd;
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      stop_test();
    end
  end

  always @(negedge clk_sys)
  begin
    if (rd_d)
    begin
      chk("csr_rdata", exp_q.pop_front(), csr_rdata_q);
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(5483));
    cyc(8);
    rst = 1'b0;
    rd(OFS_EVENT_SET, EVENT_RESET);
    rd(OFS_MASK_SET, MASK_RESET);
    rd(OFS_ERR_REPORT, {28'h0, ERR_RESET});
    rd(8'h20, 32'h0);
    r = $urandom();
    wr(OFS_MASK_SET, r);
    rd(OFS_MASK_CLR, r & MASK_WR_MASK);
    wr(OFS_MASK_CLR, r);
    rd(OFS_MASK_SET, 32'h0);
    wr(OFS_EVENT_SET, r);
    wr(OFS_MASK_SET, 32'h0000_0005);
    rd(OFS_EVENT_SET, r & EVENT_WR_MASK);
    rd(OFS_EVENT_CLR, r & EVENT_WR_MASK & 32'h5);
    wr(OFS_EVENT_CLR, 32'hffff_ffff);
    wr(OFS_MASK_CLR, 32'hffff_ffff);
    rd(OFS_EVENT_SET, 32'h0);
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      dsp_host_irq_lines[i] = 1'b1;
      cyc(5);
      dsp_host_irq_lines[i] = 1'b0;
      rd(OFS_EVENT_SET, 32'h1 << i);
      wr(OFS_MASK_SET, 32'h8000_0000 | (32'h1 << i));
      cyc(3);
      chk("inta", 32'h1, {31'h0, inta_q});
      power_state = 2'(i);
      cyc(3);
      chk("inta_pwr", {31'h0, i == 0}, {31'h0, inta_q});
      power_state = PWR_D0;
      wr(OFS_EVENT_CLR, 32'h1 << i);
      cyc(3);
      chk("inta_clr", 32'h0, {31'h0, inta_q});
      wr(OFS_MASK_CLR, 32'hffff_ffff);
    end
    wr(OFS_EVENT_SET, 32'h1);
    wr(OFS_MASK_SET, 32'h8000_0001);
    power_state = 2'b11;
    pm_csr = 16'h8100;
    cyc(3);
    chk("pme", 32'h1, {31'h0, pme_q});
    pm_csr = 16'h8000;
    cyc(3);
    chk("pme_off", 32'h0, {31'h0, pme_q});
    power_state = PWR_D0;
    wr(OFS_EVENT_CLR, 32'hffff_ffff);
    wr(OFS_MASK_CLR, 32'hffff_ffff);
    for (int k = 0; k < 8; k++)
    begin
      misc_ctrl = 8'(k[0]) << BIT_PM_REV_SEL;
      cold_wake_support = k[1];
      pm_cap_hi = {k[1], 6'($urandom())};
      pm_cap_bit5 = k[2];
      pm_cap_bit3 = ~k[2];
      cyc(3);
      e = {16'h0, pm_cap_hi, (k[0] && k[1]) ? AUX_CUR_COLD : AUX_CUR_NONE, pm_cap_bit5, ~k[0],
        pm_cap_bit3, k[0] ? PM11_VERSION : 3'b001};
      chk("pm_caps", e, {16'h0, power_mgmt_capabilities_q});
    end
    // prompt dsp and disabled timer must both stay quiet
    port_select_n[1] = 1'b0;
    cyc(300);
    port_select_n[1] = 1'b1;
    stall[0] = 1'b1;
    diag_reg[BIT_READY_TO_DIS] = 1'b1;
    port_select_n[0] = 1'b0;
    cyc(300);
    port_select_n[0] = 1'b1;
    diag_reg = 8'h00;
    rd(OFS_ERR_REPORT, 32'h0);
    port_select_n[0] = 1'b0;
    cyc(248);
    rd(OFS_ERR_REPORT, 32'h0);
    cyc(8);
    rd(OFS_ERR_REPORT, 32'h1);
    port_select_n[0] = 1'b1;
    stall[0] = 1'b0;
    rd(OFS_EVENT_SET, 32'h4000_0000);
    wr(OFS_MASK_SET, 32'hc000_0000);
    cyc(3);
    chk("inta_fault", 32'h1, {31'h0, inta_q});
    chk("abort_off", 32'h0, {31'h0, target_abort_q});
    serr_pulse(1'b1, 1'b0);
    serr_pulse(1'b0, 1'b1);
    wr(OFS_MASK_CLR, 32'h4000_0000);
    serr_pulse(1'b1, 1'b1);
    wr(OFS_MASK_CLR, 32'hffff_ffff);
    wr(OFS_ERR_REPORT, 32'hf);
    cyc(2);
    rd(OFS_EVENT_SET, 32'h0);
    narrow_port = 4'b0100;
    foreach (be_tab[j])
    begin
      byte_en_n = be_tab[j];
      be_valid[2] = 1'b1;
      @(negedge clk_sys);
      be_valid[2] = 1'b0;
      cyc(1);
      chk("abort", {31'h0, j == 3}, {31'h0, target_abort_q});
      chk("zero_data", 32'h0, {31'h0, zero_data_q});
      cyc(2);
      rd(OFS_ERR_REPORT, (j == 3) ? 32'h4 : 32'h0);
    end
    // same bad pattern again, now in zero-data mode
    wr(OFS_MASK_SET, 32'h4000_0000);
    be_valid[2] = 1'b1;
    @(negedge clk_sys);
    be_valid[2] = 1'b0;
    cyc(1);
    chk("zero_data", 32'h1, {31'h0, zero_data_q});
    chk("abort", 32'h0, {31'h0, target_abort_q});
    wr(OFS_MASK_CLR, 32'h4000_0000);
    wr(OFS_ERR_REPORT, 32'hf);
    read_pending[3] = 1'b1;
    cyc(DISC + 6);
    read_pending[3] = 1'b0;
    rd(OFS_ERR_REPORT, 32'h8);
    wr(OFS_ERR_REPORT, 32'hf);
    pin3_sel = 1'b1;
    pin2_sel = 1'b1;
    cyc(4);
    pin3_in = 1'b0;
    pin2_in = 1'b0;
    cyc(5);
    pin3_in = 1'b1;
    cyc(5);
    rd(OFS_EVENT_SET, 32'h1800_0000);
    wr(OFS_EVENT_CLR, 32'hffff_ffff);
    // swap modes: low pin 2 now re-fires, steady pin 3 stays quiet
    p3_chg = 1'b1;
    p2_chg = 1'b0;
    cyc(3);
    rd(OFS_EVENT_SET, 32'h0800_0000);
    pin2_in = 1'b1;
    cyc(4);
    wr(OFS_EVENT_CLR, 32'hffff_ffff);
    rd(OFS_EVENT_SET, 32'h0);
    cyc(4);
    stop_test();
  end
endmodule : irq_pm_ctrl_tb
